/* core/two_step_adc.sv */
// two-step converter timing core with its output fifo
// Operation
// - each sample is resolved into one of 1024 codes on a 10-bit word.
// - conversion follows the conversion clock and a sample is out two periods after its sampling phase ends.
// - clock high is the balance phase and clock low is the sampling phase.
// - a rising conversion clock edge ends sampling and the sample is taken after the aperture delay.
// - the coarse stage picks the sub-range and the fine stage resolves inside it in the next balance phase.
// - overflow is a separate flag from digital logic and never alters the data bits.
// - the code is 1023 times the input above the negative reference over the reference span, straight binary.
// - the encoded result passes two cascaded flip-flop stages before the data outputs.
`timescale 1ns/100ps
`include "two_step_adc_consts.svh"

module two_step_adc_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             valid_q;
  logic [WIDTH-1:0] data_q;
  wire              full = (count_q == (AW+1)'(DEPTH));
  wire              empty = (count_q == '0);
  wire              push = in_valid && !full;
  wire              load = !empty && (!valid_q || out_ready);

  assign in_ready  = !full;
  assign out_valid = valid_q;
  assign out_data  = data_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      valid_q  <= 1'b0;
      data_q   <= '0;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= load ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q  <= count_q + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        data_q  <= mem[rd_ptr_q];
        valid_q <= 1'b1;
      end else if (out_ready) begin
        valid_q <= 1'b0;
      end
    end
  end
endmodule

module two_step_adc
  import two_step_adc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // conversion clock from the host
  input  wire logic                 conv_clk,
  // analog input above negative reference, and reference span, as levels
  input  wire logic [`LEVEL_W-1:0]  ain_level,
  input  wire logic [`LEVEL_W-1:0]  ref_span,
  // data pins, code_bits[9] is code_bit_msb and code_bits[0] is code_bit_lsb
  output logic [`CODE_W-1:0]        code_bits,
  output logic                      overflow,
  output logic                      balance_phase,
  // result stream
  output logic                      res_valid,
  input  wire logic                 res_ready,
  output logic [`FIFO_WIDTH-1:0]    res_data,
  output logic                      res_stall
);
  logic [1:0]                ck_sync_q;
  logic                      ck_q;
  logic [`LEVEL_W-1:0]       ain_meta_q;
  logic [`LEVEL_W-1:0]       ain_q;
  logic [`LEVEL_W-1:0]       span_meta_q;
  logic [`LEVEL_W-1:0]       span_q;
  conv_state_t               state_q;
  conv_state_t               state_d;
  logic [`APERTURE_CNT_W-1:0] ap_cnt_q;
  logic [`LEVEL_W-1:0]       held_q;
  logic [`COARSE_MSB-`COARSE_LSB:0] coarse_q;
  logic [`CODE_W:0]          stage1_q;
  logic [`CODE_W-1:0]        code_q;
  logic                      ovf_q;
  logic                      bal_q;
  logic                      stall_q;
  logic                      fifo_ready;

  // two-flop synchronisers on the pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_sync_q   <= '1; // idle conversion clock is high, no false rise after reset
      ck_q        <= 1'b1;
      ain_meta_q  <= '0;
      ain_q       <= '0;
      span_meta_q <= '0;
      span_q      <= '0;
    end else begin
      ck_sync_q   <= {ck_sync_q[0], conv_clk};
      ck_q        <= ck_sync_q[1];
      ain_meta_q  <= ain_level;
      ain_q       <= ain_meta_q;
      span_meta_q <= ref_span;
      span_q      <= span_meta_q;
    end
  end

  wire ck_now  = ck_sync_q[1];
  wire ck_rise = ck_now && !ck_q;
  wire ck_fall = !ck_now && ck_q;
  wire advance = ck_rise && fifo_ready;

  // transfer function on the live input and on the held sample
  wire [25:0] live_prod = {10'h000, ain_q} * `CODE_SCALE;
  wire [25:0] held_prod = {10'h000, held_q} * `CODE_SCALE;
  wire        live_top  = (span_q == '0) || (ain_q >= span_q);
  wire        held_top  = (span_q == '0) || (held_q >= span_q);
  wire [25:0] live_quo  = live_top ? 26'h0 : live_prod / {10'h000, span_q};
  wire [25:0] held_quo  = held_top ? 26'h0 : held_prod / {10'h000, span_q};
  wire [`CODE_W-1:0] live_code = live_top ? `CODE_FULL : live_quo[`CODE_W-1:0];
  wire [`CODE_W-1:0] held_code = held_top ? `CODE_FULL : held_quo[`CODE_W-1:0];
  // overflow once the input passes the full span less half an lsb
  wire [27:0] ovf_lhs   = {12'h000, held_q} * `OFW_NUM;
  wire [27:0] ovf_rhs   = {12'h000, span_q} * `OFW_DEN;
  wire        held_ovf  = ovf_lhs >= ovf_rhs;
  wire [`FINE_MSB:0] fine = held_code[`FINE_MSB:0];
  wire        ap_done   = (ap_cnt_q == `APERTURE_CNT_W'(`APERTURE_CYC - 1));

  // phase sequencer: sample while low, aperture after rise, balance while high
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SAMPLE: begin
        if (ck_rise) begin
          state_d = ST_APERTURE;
        end
      end
      ST_APERTURE: begin
        if (ap_done) begin
          state_d = ck_now ? ST_BALANCE : ST_SAMPLE;
        end
      end
      ST_BALANCE: begin
        if (ck_fall) begin
          state_d = ST_SAMPLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q  <= ST_BALANCE;
      ap_cnt_q <= '0;
      held_q   <= '0;
      coarse_q <= '0;
      bal_q    <= 1'b1;
    end else begin
      state_q  <= state_d;
      ap_cnt_q <= (state_q == ST_APERTURE) ? ap_cnt_q + 1'b1 : '0;
      bal_q    <= (state_d != ST_SAMPLE);
      if (state_q == ST_APERTURE && ap_done) begin
        held_q   <= ain_q;
        coarse_q <= live_code[`COARSE_MSB:`COARSE_LSB];
      end
    end
  end

  // two cascaded stages, one per conversion clock rise; full fifo holds them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_q <= '0;
      code_q   <= '0;
      ovf_q    <= 1'b0;
      stall_q  <= 1'b0;
    end else begin
      stall_q <= !fifo_ready;
      if (advance) begin
        stage1_q <= {held_ovf, coarse_q, fine};
        code_q   <= stage1_q[`CODE_W-1:0];
        ovf_q    <= stage1_q[`CODE_W];
      end
    end
  end

  assign code_bits     = code_q;
  assign overflow      = ovf_q;
  assign balance_phase = bal_q;
  assign res_stall     = stall_q;

  two_step_adc_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (advance),
    .in_ready  (fifo_ready),
    .in_data   (stage1_q),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );
endmodule

/* core/two_step_adc_consts.svh */
// constants for the two-step converter model
`ifndef TWO_STEP_ADC_CONSTS_SVH
`define TWO_STEP_ADC_CONSTS_SVH
`define CODE_W          10
`define CODE_FULL       10'h3ff
`define CODE_SCALE      26'h00003ff
`define COARSE_MSB      9
`define COARSE_LSB      6
`define FINE_MSB        5
`define LEVEL_W         16
`define OFW_NUM         28'h0000800
`define OFW_DEN         28'h00007ff
`define CLK_PERIOD_NS   20
`define APERTURE_NS     35
`define APERTURE_CYC    ((`APERTURE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define APERTURE_CNT_W  2
`define FIFO_WIDTH      11
`define FIFO_DEPTH      32
`endif

/* core/two_step_adc_pkg.sv */
// types for the two-step converter model
package two_step_adc_pkg;
  typedef enum logic [2:0] {
    ST_SAMPLE   = 3'b001,
    ST_APERTURE = 3'b010,
    ST_BALANCE  = 3'b100
  } conv_state_t;
endpackage

/* verif/adc_host_model.sv */
// host model: conversion clock bursts and stream capture
`timescale 1ns/100ps
module adc_host_model (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        run,
  input wire logic        drain,
  output logic            conv_clk,
  output logic            res_ready,
  input wire logic        res_valid,
  input wire logic [10:0] res_data,
  output logic [10:0]     last_word,
  output int              n_words
);
  logic [3:0] ph_q;
  assign res_ready = drain;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_q      <= 4'h0;
      conv_clk  <= 1'b1;
      n_words   <= 0;
      last_word <= 11'h000;
    end else begin
      ph_q     <= run ? ph_q + 4'h1 : 4'h0;
      conv_clk <= !run || ph_q[3];
      if (res_valid && res_ready) begin
        n_words   <= n_words + 1;
        last_word <= res_data;
      end
    end
  end
endmodule

/* verif/two_step_adc_assertions.sv */
// port assertions for the converter core
`timescale 1ns/100ps
module two_step_adc_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // conversion side
  input wire logic        conv_clk,
  input wire logic [9:0]  code_bits,
  input wire logic        overflow,
  input wire logic        balance_phase,
  // stream side
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic [10:0] res_data,
  input wire logic        res_stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence held_high; conv_clk [*5]; endsequence
  sequence code_moved; !$stable(code_bits); endsequence
  a_code_on_rise: assert property (code_moved |-> $past(conv_clk, 2))
    else $error("code moved away from a clock rise");
  a_ovf_on_rise: assert property (!$stable(overflow) |-> $past(conv_clk, 2))
    else $error("overflow moved away from a clock rise");
  a_ovf_near_full: assert property (overflow |-> code_bits >= 10'h3fe)
    else $error("overflow flag with a low code");
  a_balance_high: assert property (held_high |-> balance_phase)
    else $error("not balancing while clock high");
  a_word_holds: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("stream word dropped before taken");
  a_stall_freeze: assert property (res_stall [*3] |-> $stable(code_bits))
    else $error("pipeline moved while full");
  a_push_valid: assert property ((code_moved and !res_stall) |-> ##[1:3] res_valid)
    else $error("new code not offered on stream");
  a_reset_state: assert property (disable iff (1'b0) sys_rst |=> code_bits == 10'h000 && !res_valid && balance_phase)
    else $error("bad state in reset");
endmodule
bind two_step_adc two_step_adc_assertions i_chk (.clk, .sys_rst, .conv_clk, .code_bits, .overflow, .balance_phase,
  .res_valid, .res_ready, .res_data, .res_stall);

/* verif/two_step_adc_conversion_timing_test.sv */
// self-checking bench for the converter core
`timescale 1ns/100ps
module two_step_adc_conversion_timing_test;
  logic        clk, sys_rst, run, drain, conv_clk, overflow, balance_phase, res_valid, res_ready, res_stall;
  logic [15:0] ain_level, ref_span;
  logic [9:0]  code_bits;
  logic [10:0] res_data, last_word;
  int          n_words, n_errors, total_checks, w0;
  two_step_adc i_dut (.clk, .sys_rst, .conv_clk, .ain_level, .ref_span, .code_bits, .overflow, .balance_phase,
    .res_valid, .res_ready, .res_data, .res_stall);
  adc_host_model i_host (.clk, .sys_rst, .run, .drain, .conv_clk, .res_ready, .res_valid, .res_data, .last_word,
    .n_words);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task err(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task pulses(input int n);
    run <= 1'b1;
    repeat (n * 16) @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task t_convert(input logic [15:0] a, input logic [15:0] s, input logic [9:0] c, input logic o);
    ain_level <= a;
    ref_span  <= s;
    drain     <= 1'b1;
    w0 = n_words;
    pulses(3);
    total_checks += 4;
    if (code_bits !== c) err("code word");
    if (overflow !== o) err("overflow flag");
    if (last_word !== {o, c}) err("stream word");
    if (n_words - w0 != 3) err("words per rise");
    $display("convert test done");
  endtask
  task t_latency();
    ain_level <= 16'h0010;
    pulses(2);
    total_checks += 2;
    if (code_bits !== 10'h064) err("code before latency");
    pulses(1);
    if (code_bits !== 10'h010) err("code after latency");
    $display("latency test done");
  endtask
  task t_fill();
    drain <= 1'b0;
    pulses(40);
    total_checks += 3;
    if (res_stall !== 1'b1) err("no stall when full");
    w0 = n_words;
    drain <= 1'b1;
    repeat (80) @(posedge clk);
    if (n_words - w0 != 33) err("buffer depth");
    if (res_valid !== 1'b0) err("buffer not empty");
    $display("fill test done");
  endtask
  task results();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err("watchdog expired");
    results();
  end
  initial begin
    sys_rst = 1'b1;
    run = 1'b0;
    drain = 1'b0;
    ain_level = 16'h0000;
    ref_span = 16'h0400;
    repeat (6) @(posedge clk);
    total_checks += 1;
    if (code_bits !== 10'h000 || res_valid !== 1'b0 || balance_phase !== 1'b1) err("reset state");
    sys_rst <= 1'b0;
    t_convert(16'h0200, 16'h0400, 10'h1ff, 1'b0);
    t_convert(16'h03e7, 16'h03e8, 10'h3fd, 1'b0);
    t_convert(16'h07ff, 16'h0800, 10'h3fe, 1'b1);
    t_convert(16'h04b0, 16'h03e8, 10'h3ff, 1'b1);
    t_convert(16'h0100, 16'h0000, 10'h3ff, 1'b1);
    t_convert(16'h0064, 16'h03ff, 10'h064, 1'b0);
    t_latency();
    t_fill();
    results();
  end
endmodule
